// >>> verilog/srl_latch_top.sv
// set/reset latch with selectable set and reset sources, wishbone register slave
`timescale 1ns/1ps

// Summary of operation
// - divider pulse drives set when enabled
// - second comparator sets latch when enabled
// - first comparator sets latch when enabled
// - peripheral reset input resets latch when enabled
// - divider pulse drives reset when enabled
// - second comparator resets latch when enabled
// - first comparator resets latch when enabled
// - divider pulses every 4 to 512 cycles
// - software pulse bits strobe one cycle, read zero
// - latch works only with master enable set
// - latch state need not be reset
module srl_latch_top (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // wishbone slave
  input  wire logic [srl_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire logic [srl_pkg::WB_DW-1:0]   wb_dat_i,
  output logic      [srl_pkg::WB_DW-1:0]   wb_dat_o,
  input  wire logic [srl_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic                        wb_we_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  output logic                             wb_ack_o,
  // latch sources from outside the clock domain
  input  wire logic                        periph_set_i,
  input  wire logic                        periph_reset_i,
  input  wire logic                        cmp1_i,
  input  wire logic                        cmp2_i,
  // latch output pins
  output logic                             q_o,
  output logic                             q_oe_o,
  output logic                             nq_o,
  output logic                             nq_oe_o
);
  import srl_pkg::*;

  // address decode shared by the read and write paths
  function automatic logic [REG_IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] adr);
    if (adr == ADR_CONTROL_MAIN)
      reg_index = RIDX_CONTROL;
    else if (adr == ADR_SOURCE_EN)
      reg_index = RIDX_SOURCE;
    else if (adr == ADR_LATCH_STATUS)
      reg_index = RIDX_STATUS;
    else
      reg_index = RIDX_NONE;
  endfunction

  // bus handshake state
  srl_bus_state_t          bus_state_r;
  srl_bus_state_t          bus_state_nxt;
  logic [WB_DW-1:0]        rdata_r;
  logic [WB_DW-1:0]        rdata_nxt;
  logic                    req;
  logic                    wr_commit;
  logic                    lane0_wr;

  // control and enable registers
  logic                    master_en_r;
  logic                    master_en_nxt;
  logic [DIV_SEL_W-1:0]    div_sel_r;
  logic [DIV_SEL_W-1:0]    div_sel_nxt;
  logic                    true_oe_en_r;
  logic                    true_oe_en_nxt;
  logic                    inv_oe_en_r;
  logic                    inv_oe_en_nxt;
  logic                    soft_set_r;
  logic                    soft_set_nxt;
  logic                    soft_rst_r;
  logic                    soft_rst_nxt;
  logic [REG_W-1:0]        src_en_r;
  logic [REG_W-1:0]        src_en_nxt;

  // input synchroniser
  logic [EXT_N-1:0]        ext_raw;
  logic [EXT_N-1:0]        sync1_r;
  logic [EXT_N-1:0]        sync2_r;

  // latch core
  logic                    div_pulse;
  logic [SRC_N-1:0]        set_src;
  logic [SRC_N-1:0]        rst_src;
  logic [SRC_N-1:0]        set_term;
  logic [SRC_N-1:0]        rst_term;
  logic                    set_in;
  logic                    rst_in;
  logic                    latch_r;
  logic                    latch_nxt;
  logic                    q_oe_r;
  logic                    q_oe_nxt;
  logic                    nq_oe_r;
  logic                    nq_oe_nxt;

  // readback words
  logic [REG_W-1:0]        control_rd;
  logic [REG_W-1:0]        status_rd;

  // ------------------------------------------------------------------
  // wishbone classic: ack one cycle after the request, then dropped
  // ------------------------------------------------------------------
  assign req       = wb_cyc_i && wb_stb_i;
  assign wr_commit = req && wb_we_i && (bus_state_r == SRL_BUS_ACK);
  assign lane0_wr  = wr_commit && wb_sel_i[0];

  always_comb
  begin
    control_rd                                  = '0;
    control_rd[CM_MASTER_EN_BIT]                = master_en_r;
    control_rd[CM_DIV_LSB +: DIV_SEL_W]         = div_sel_r;
    control_rd[CM_TRUE_OE_BIT]                  = true_oe_en_r;
    control_rd[CM_INV_OE_BIT]                   = inv_oe_en_r;
    // pulse bits are write-only strobes and read as zero
    control_rd[CM_PULSE_SET_BIT]                = 1'b0;
    control_rd[CM_PULSE_RST_BIT]                = 1'b0;
    status_rd                                   = '0;
    status_rd[ST_LATCH_BIT]                     = latch_r;
    status_rd[ST_SET_BIT]                       = set_in;
    status_rd[ST_RST_BIT]                       = rst_in;
    status_rd[ST_DIV_BIT]                       = div_pulse;
    status_rd[ST_EXT_LSB +: EXT_N]              = sync2_r;
  end

  always_comb
  begin
    bus_state_nxt = bus_state_r;
    rdata_nxt     = rdata_r;
    case (bus_state_r)
      SRL_BUS_IDLE:
      begin
        if (req)
        begin
          bus_state_nxt = SRL_BUS_ACK;
          case (reg_index(wb_adr_i))
            RIDX_CONTROL: rdata_nxt = WB_DW'(control_rd);
            RIDX_SOURCE:  rdata_nxt = WB_DW'(src_en_r);
            RIDX_STATUS:  rdata_nxt = WB_DW'(status_rd);
            default:      rdata_nxt = '0;
          endcase
        end
      end
      SRL_BUS_ACK:
      begin
        bus_state_nxt = SRL_BUS_IDLE;
        rdata_nxt     = '0;
      end
      default:
      begin
        bus_state_nxt = SRL_BUS_IDLE;
        rdata_nxt     = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state_r <= SRL_BUS_IDLE;
      rdata_r     <= '0;
    end
    else
    begin
      bus_state_r <= bus_state_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign wb_ack_o = (bus_state_r == SRL_BUS_ACK);
  assign wb_dat_o = rdata_r;

  // ------------------------------------------------------------------
  // register writes take effect on the edge that samples ack
  // ------------------------------------------------------------------
  always_comb
  begin
    master_en_nxt  = master_en_r;
    div_sel_nxt    = div_sel_r;
    true_oe_en_nxt = true_oe_en_r;
    inv_oe_en_nxt  = inv_oe_en_r;
    src_en_nxt     = src_en_r;
    soft_set_nxt   = 1'b0;
    soft_rst_nxt   = 1'b0;
    if (lane0_wr)
    begin
      if (reg_index(wb_adr_i) == RIDX_CONTROL)
      begin
        master_en_nxt  = wb_dat_i[CM_MASTER_EN_BIT];
        div_sel_nxt    = wb_dat_i[CM_DIV_LSB +: DIV_SEL_W];
        true_oe_en_nxt = wb_dat_i[CM_TRUE_OE_BIT];
        inv_oe_en_nxt  = wb_dat_i[CM_INV_OE_BIT];
        soft_set_nxt   = wb_dat_i[CM_PULSE_SET_BIT];
        soft_rst_nxt   = wb_dat_i[CM_PULSE_RST_BIT];
      end
      else if (reg_index(wb_adr_i) == RIDX_SOURCE)
      begin
        src_en_nxt = wb_dat_i[REG_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      master_en_r  <= CONTROL_RST[CM_MASTER_EN_BIT];
      div_sel_r    <= DIV_SEL_RST;
      true_oe_en_r <= CONTROL_RST[CM_TRUE_OE_BIT];
      inv_oe_en_r  <= CONTROL_RST[CM_INV_OE_BIT];
      soft_set_r   <= 1'b0;
      soft_rst_r   <= 1'b0;
      src_en_r     <= SOURCE_EN_RST;
    end
    else
    begin
      master_en_r  <= master_en_nxt;
      div_sel_r    <= div_sel_nxt;
      true_oe_en_r <= true_oe_en_nxt;
      inv_oe_en_r  <= inv_oe_en_nxt;
      soft_set_r   <= soft_set_nxt;
      soft_rst_r   <= soft_rst_nxt;
      src_en_r     <= src_en_nxt;
    end
  end

  // ------------------------------------------------------------------
  // two-stage synchroniser on the pin and comparator inputs
  // ------------------------------------------------------------------
  always_comb
  begin
    ext_raw                 = '0;
    ext_raw[EXT_CMP1]       = cmp1_i;
    ext_raw[EXT_CMP2]       = cmp2_i;
    ext_raw[EXT_PERIPH_SET] = periph_set_i;
    ext_raw[EXT_PERIPH_RST] = periph_reset_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= ext_raw;
      sync2_r <= sync1_r;
    end
  end

  // ------------------------------------------------------------------
  // divider pulse source
  // ------------------------------------------------------------------
  srl_divider #(
    .CNT_W     (DIV_CNT_W)
  ) u_divider (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (master_en_r),
    .div_sel_i (div_sel_r),
    .pulse_o   (div_pulse)
  );

  // ------------------------------------------------------------------
  // source gating and combining
  // ------------------------------------------------------------------
  always_comb
  begin
    set_src             = '0;
    set_src[SRC_CMP1]   = sync2_r[EXT_CMP1];
    set_src[SRC_CMP2]   = sync2_r[EXT_CMP2];
    set_src[SRC_CLK]    = div_pulse;
    set_src[SRC_PERIPH] = sync2_r[EXT_PERIPH_SET];
    rst_src             = '0;
    rst_src[SRC_CMP1]   = sync2_r[EXT_CMP1];
    rst_src[SRC_CMP2]   = sync2_r[EXT_CMP2];
    rst_src[SRC_CLK]    = div_pulse;
    rst_src[SRC_PERIPH] = sync2_r[EXT_PERIPH_RST];
  end

  // each enable bit passes or blocks exactly one source
  genvar g;
  generate
    for (g = 0; g < SRC_N; g++)
    begin : g_gate
      assign set_term[g] = src_en_r[SE_SET_LSB + g] & set_src[g];
      assign rst_term[g] = src_en_r[SE_RESET_LSB + g] & rst_src[g];
    end
  endgenerate

  assign set_in = (|set_term) | soft_set_r;
  assign rst_in = (|rst_term) | soft_rst_r;

  // ------------------------------------------------------------------
  // latch core: reset input dominates when both are active
  // ------------------------------------------------------------------
  always_comb
  begin
    latch_nxt = latch_r;
    if (master_en_r)
    begin
      if (rst_in)
        latch_nxt = 1'b0;
      else if (set_in)
        latch_nxt = 1'b1;
    end
    q_oe_nxt  = master_en_r && true_oe_en_r;
    nq_oe_nxt = master_en_r && inv_oe_en_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // latch content is not meaningful after reset; cleared only to avoid X
      latch_r <= 1'b0;
      q_oe_r  <= 1'b0;
      nq_oe_r <= 1'b0;
    end
    else
    begin
      latch_r <= latch_nxt;
      q_oe_r  <= q_oe_nxt;
      nq_oe_r <= nq_oe_nxt;
    end
  end

  assign q_o     = latch_r;
  assign nq_o    = ~latch_r;
  assign q_oe_o  = q_oe_r;
  assign nq_oe_o = nq_oe_r;

endmodule // srl_latch_top

// >>> verilog/srl_pkg.sv
// shared constants and types for the set/reset latch source selection block
package srl_pkg;

  // bus geometry
  localparam int WB_DW  = 32;
  localparam int ADDR_W = 4;
  localparam int SEL_W  = 4;
  localparam int REG_W  = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADR_CONTROL_MAIN  = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_SOURCE_EN     = 4'h4;
  localparam logic [ADDR_W-1:0] ADR_LATCH_STATUS  = 4'h8;

  // decoded register index
  localparam int REG_IDX_W = 2;
  localparam logic [REG_IDX_W-1:0] RIDX_CONTROL = 2'h0;
  localparam logic [REG_IDX_W-1:0] RIDX_SOURCE  = 2'h1;
  localparam logic [REG_IDX_W-1:0] RIDX_STATUS  = 2'h2;
  localparam logic [REG_IDX_W-1:0] RIDX_NONE    = 2'h3;

  // latch_control_main fields
  localparam int CM_MASTER_EN_BIT = 7;
  localparam int CM_DIV_LSB       = 4;
  localparam int DIV_SEL_W        = 3;
  localparam int CM_TRUE_OE_BIT   = 3;
  localparam int CM_INV_OE_BIT    = 2;
  localparam int CM_PULSE_SET_BIT = 1;
  localparam int CM_PULSE_RST_BIT = 0;

  // latch_source_enables fields: four set enables above four reset enables
  localparam int SE_SET_LSB   = 4;
  localparam int SE_RESET_LSB = 0;
  localparam int SRC_N        = 4;

  // source index inside each half
  localparam int SRC_CMP1   = 0;
  localparam int SRC_CMP2   = 1;
  localparam int SRC_CLK    = 2;
  localparam int SRC_PERIPH = 3;

  // external input index for the synchroniser
  localparam int EXT_N          = 4;
  localparam int EXT_CMP1       = 0;
  localparam int EXT_CMP2       = 1;
  localparam int EXT_PERIPH_SET = 2;
  localparam int EXT_PERIPH_RST = 3;

  // latch_status fields
  localparam int ST_LATCH_BIT = 7;
  localparam int ST_SET_BIT   = 6;
  localparam int ST_RST_BIT   = 5;
  localparam int ST_DIV_BIT   = 4;
  localparam int ST_EXT_LSB   = 0;

  // reset values
  localparam logic [REG_W-1:0]     CONTROL_RST   = 8'h00;
  localparam logic [REG_W-1:0]     SOURCE_EN_RST = 8'h00;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RST   = 3'h0;

  // divider: shortest period is two to the DIV_MIN_LOG2, longest needs DIV_CNT_W bits
  localparam int DIV_MIN_LOG2 = 2;
  localparam int DIV_CNT_W    = 9;

  typedef enum logic [0:0] {
    SRL_BUS_IDLE = 1'b0,
    SRL_BUS_ACK  = 1'b1
  } srl_bus_state_t;

endpackage

// >>> verilog/srl_divider.sv
// periodic one-cycle pulse generator for the latch clock source
`timescale 1ns/1ps
module srl_divider #(
  parameter int CNT_W = srl_pkg::DIV_CNT_W
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // control
  input  wire logic                         en_i,
  input  wire logic [srl_pkg::DIV_SEL_W-1:0] div_sel_i,
  // pulse out
  output logic                              pulse_o
);
  import srl_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             pulse_r;
  logic             pulse_nxt;
  logic [CNT_W:0]   span;
  logic [CNT_W-1:0] mask;

  // period is 4 shifted left by the select code
  always_comb
  begin
    span      = (CNT_W+1)'(1) << (DIV_MIN_LOG2 + int'(div_sel_i));
    mask      = CNT_W'(span - 1'b1);
    cnt_nxt   = en_i ? CNT_W'(cnt_r + 1'b1) : '0;
    pulse_nxt = en_i && ((cnt_r & mask) == mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r   <= '0;
      pulse_r <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse_o = pulse_r;

endmodule // srl_divider

// >>> bench/srl_src_model.sv
// far-side model: comparator outputs and peripheral latch source pins
`timescale 1ns/1ps
module srl_src_model #(
  parameter bit SLOW = 1'b0
) (
  // clock
  input  wire logic                      clk_i,
  // commanded levels, indexed as the synchroniser inputs
  input  wire logic [srl_pkg::EXT_N-1:0] lvl_i,
  // source pins
  output logic                           cmp1_o,
  output logic                           cmp2_o,
  output logic                           periph_set_o,
  output logic                           periph_reset_o
);
  import srl_pkg::*;
  logic [EXT_N-1:0] src_r;
  logic [EXT_N-1:0] late_r;
  logic [EXT_N-1:0] pin;
  // slow mode adds one cycle of lag, as a sluggish comparator would
  always_ff @(posedge clk_i)
  begin
    src_r  <= lvl_i;
    late_r <= src_r;
  end
  assign pin            = SLOW ? late_r : src_r;
  assign cmp1_o         = pin[EXT_CMP1];
  assign cmp2_o         = pin[EXT_CMP2];
  assign periph_set_o   = pin[EXT_PERIPH_SET];
  assign periph_reset_o = pin[EXT_PERIPH_RST];
endmodule // srl_src_model

// >>> bench/srl_latch_checker.sv
// port assertions for the latch source selection block
`timescale 1ns/1ps
module srl_latch_checker (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  // wishbone
  input wire logic [srl_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [srl_pkg::WB_DW-1:0]  wb_dat_i,
  input wire logic [srl_pkg::WB_DW-1:0]  wb_dat_o,
  input wire logic [srl_pkg::SEL_W-1:0]  wb_sel_i,
  input wire logic                       wb_we_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_ack_o,
  // sources and outputs
  input wire logic                       periph_set_i,
  input wire logic                       periph_reset_i,
  input wire logic                       cmp1_i,
  input wire logic                       cmp2_i,
  input wire logic                       q_o,
  input wire logic                       q_oe_o,
  input wire logic                       nq_o,
  input wire logic                       nq_oe_o
);
  import srl_pkg::*;
  logic men_r;
  logic men_nxt;
  logic wr_ctrl;
  logic [1:0] oe_req;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the master enable, taken from snooped control writes
  assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
                 & (wb_adr_i == ADR_CONTROL_MAIN);
  // requested output enables, each gated by the master enable bit of the same write
  assign oe_req = {wb_dat_i[7] & wb_dat_i[3], wb_dat_i[7] & wb_dat_i[2]};
  always_comb men_nxt = rst_i ? 1'b0 : (wr_ctrl ? wb_dat_i[CM_MASTER_EN_BIT] : men_r);
  always_ff @(posedge clk_i) men_r <= men_nxt;

  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");
  pulse_bits_zero_a: assert property (wb_ack_o && !$past(wb_we_i) &&
    ($past(wb_adr_i) == ADR_CONTROL_MAIN) |-> wb_dat_o[1:0] == 2'h0)
    else $error("pulse bits read back nonzero");
  soft_set_a: assert property (wr_ctrl && wb_dat_i[7] && wb_dat_i[1] && !wb_dat_i[0]
    |-> ##2 q_o) else $error("soft set did not set latch");
  soft_reset_a: assert property (wr_ctrl && wb_dat_i[7] && wb_dat_i[0] |-> ##2 !q_o)
    else $error("soft reset did not clear latch");
  hold_off_a: assert property (!men_r |=> $stable(q_o))
    else $error("latch moved while disabled");
  oe_follow_a: assert property (wr_ctrl |-> ##2
    ({q_oe_o, nq_oe_o} == $past(oe_req, 2)))
    else $error("output enables do not follow control write");
  oe_off_a: assert property (!men_r && !$past(men_r) |-> !q_oe_o && !nq_oe_o)
    else $error("output enabled while latch disabled");
  inv_out_a: assert property (nq_o != q_o) else $error("inverted output not inverse");
endmodule // srl_latch_checker

bind srl_latch_top srl_latch_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .periph_set_i(periph_set_i), .periph_reset_i(periph_reset_i), .cmp1_i(cmp1_i),
  .cmp2_i(cmp2_i), .q_o(q_o), .q_oe_o(q_oe_o), .nq_o(nq_o), .nq_oe_o(nq_oe_o));

// >>> bench/tb.sv
// self-checking bench for the latch source selection block
`timescale 1ns/1ps
module tb;
  import srl_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [WB_DW-1:0]  wb_dat_i = '0;
  logic [WB_DW-1:0]  wb_dat_o;
  logic [SEL_W-1:0]  wb_sel_i = '0;
  logic [EXT_N-1:0]  src_lvl = '0;
  logic wb_ack_o, periph_set_i, periph_reset_i, cmp1_i, cmp2_i, q_o, q_oe_o, nq_o, nq_oe_o;
  int bad_count = 0;
  int compares = 0;

  initial forever #25 clk_i = ~clk_i;

  srl_src_model MODEL (.clk_i(clk_i), .lvl_i(src_lvl), .cmp1_o(cmp1_i), .cmp2_o(cmp2_i),
    .periph_set_o(periph_set_i), .periph_reset_o(periph_reset_i));
  srl_latch_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .periph_set_i(periph_set_i),
    .periph_reset_i(periph_reset_i), .cmp1_i(cmp1_i), .cmp2_i(cmp2_i), .q_o(q_o),
    .q_oe_o(q_oe_o), .nq_o(nq_o), .nq_oe_o(nq_oe_o));

  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle; returns one edge after the ack edge
  task automatic wb_cycle(input logic [3:0] a, input logic we, input logic [3:0] sel,
                          input logic [7:0] d, output logic [31:0] rd);
    int n;
    wb_adr_i <= a;
    wb_we_i  <= we;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      print_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] x;
    wb_cycle(a, 1'b1, 4'hF, d, x);
  endtask

  task automatic s_reset_values();
    logic [31:0] v;
    wb_cycle(ADR_SOURCE_EN, 1'b0, 4'hF, 8'h00, v);
    chk_word(v, {24'h0, SOURCE_EN_RST}, "enables after reset");
    wb_cycle(ADR_CONTROL_MAIN, 1'b0, 4'hF, 8'h00, v);
    chk_word(v, 32'h0, "control after reset");
    wb_cycle(4'hC, 1'b0, 4'hF, 8'h00, v);
    chk_word(v, 32'h0, "unmapped read");
    wb_cycle(ADR_SOURCE_EN, 1'b1, 4'hE, 8'hFF, v);
    wb_cycle(ADR_SOURCE_EN, 1'b0, 4'hF, 8'h00, v);
    chk_word(v, 32'h0, "write without byte select");
  endtask

  task automatic s_soft_pulse();
    logic [31:0] v;
    wr(ADR_CONTROL_MAIN, 8'h82);
    tick(1);
    chk_bit(q_o, 1'b1, "soft set");
    chk_bit(nq_o, 1'b0, "inverse after soft set");
    wb_cycle(ADR_CONTROL_MAIN, 1'b0, 4'hF, 8'h00, v);
    chk_word(v, 32'h80, "pulse bits read zero");
    wr(ADR_CONTROL_MAIN, 8'h81);
    tick(1);
    chk_bit(q_o, 1'b0, "soft reset");
  endtask

  task automatic s_sources();
    logic [31:0] v;
    logic [7:0] sb [3] = '{8'h10, 8'h20, 8'h80};
    logic [7:0] rb [3] = '{8'h01, 8'h02, 8'h08};
    int si [3] = '{EXT_CMP1, EXT_CMP2, EXT_PERIPH_SET};
    int ri [3] = '{EXT_CMP1, EXT_CMP2, EXT_PERIPH_RST};
    for (int s = 0; s < 3; s++)
    begin
      wr(ADR_SOURCE_EN, 8'h00);
      wr(ADR_CONTROL_MAIN, 8'h81);
      src_lvl <= 4'h1 << si[s];
      tick(8);
      chk_bit(q_o, 1'b0, "set source disabled");
      wr(ADR_SOURCE_EN, sb[s] | 8'h10);
      tick(8);
      chk_bit(q_o, 1'b1, "set source enabled");
      // status: latch and combined set high, divider bit masked as it runs free
      wb_cycle(ADR_LATCH_STATUS, 1'b0, 4'hF, 8'h00, v);
      chk_word(v & 32'hEF, 32'(8'hC0 | (8'h1 << si[s])), "status after set");
      wr(ADR_SOURCE_EN, 8'h00);
      src_lvl <= 4'h1 << ri[s];
      tick(8);
      chk_bit(q_o, 1'b1, "reset source disabled");
      wr(ADR_SOURCE_EN, rb[s] | 8'h01);
      tick(8);
      chk_bit(q_o, 1'b0, "reset source enabled");
      src_lvl <= '0;
    end
  endtask

  task automatic s_divider();
    int n;
    for (int c = 0; c < 8; c++)
    begin
      wr(ADR_SOURCE_EN, 8'h00);
      wr(ADR_CONTROL_MAIN, 8'h81);
      wr(ADR_CONTROL_MAIN, 8'h00);
      wr(ADR_SOURCE_EN, 8'h40);
      wr(ADR_CONTROL_MAIN, 8'h80 | 8'(c << CM_DIV_LSB));
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end while (q_o !== 1'b1 && n < 1000);
      chk_word(32'(n), 32'((4 << c) + 1), "divider pulse sets latch");
      if (q_o !== 1'b1)
        print_verdict();
    end
    wr(ADR_CONTROL_MAIN, 8'h80);
    wr(ADR_SOURCE_EN, 8'h04);
    tick(8);
    chk_bit(q_o, 1'b0, "divider pulse resets latch");
  endtask

  task automatic s_outputs();
    wr(ADR_SOURCE_EN, 8'h00);
    wr(ADR_CONTROL_MAIN, 8'h8C);
    tick(2);
    chk_word({30'h0, q_oe_o, nq_oe_o}, 32'h3, "output enables on");
    wr(ADR_CONTROL_MAIN, 8'h0C);
    wr(ADR_SOURCE_EN, 8'h10);
    src_lvl <= 4'h1;
    tick(8);
    chk_word({29'h0, q_oe_o, nq_oe_o, q_o}, 32'h0, "disabled latch and outputs");
    src_lvl <= '0;
  endtask

  task automatic s_mid_reset();
    logic [31:0] v;
    wr(ADR_SOURCE_EN, 8'hFF);
    wr(ADR_CONTROL_MAIN, 8'h8C);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    wb_cycle(ADR_SOURCE_EN, 1'b0, 4'hF, 8'h00, v);
    chk_word(v, {24'h0, SOURCE_EN_RST}, "enables after mid-run reset");
    chk_bit(q_oe_o | nq_oe_o, 1'b0, "output enables after reset");
  endtask

  initial
  begin
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    s_reset_values();
    s_soft_pulse();
    s_sources();
    s_divider();
    s_outputs();
    s_mid_reset();
    print_verdict();
  end
endmodule // tb
